// file: design/stb_defines.vh
`ifndef STB_DEFINES_VH
`define STB_DEFINES_VH

// clock rate and timing
`define STB_CLK_HZ          40000000
`define STB_FILT_US         500
`define STB_FILT_CYC        ((`STB_FILT_US * (`STB_CLK_HZ / 1000000)) + 1)
`define STB_MISMATCH_MS     10000
`define STB_MISMATCH_CYC    (`STB_MISMATCH_MS * (`STB_CLK_HZ / 1000))
`define STB_MON_MS          8
`define STB_MON_CYC         (`STB_MON_MS * (`STB_CLK_HZ / 1000))
`define STB_SYNC_CYC        3

// register offsets
`define STB_REG_CTRL        8'h00
`define STB_REG_STATUS      8'h04
`define STB_REG_IRQ_STAT    8'h08
`define STB_REG_IRQ_MASK    8'h0C
`define STB_REG_DELAY       8'h10

// control fields
`define STB_CTRL_MODE_LSB   0
`define STB_CTRL_MODE_W     4
`define STB_CTRL_SVON_BIT   4
`define STB_CTRL_ALM_BIT    5
`define STB_CTRL_RST        8'h00
`define STB_DELAY_RST       16'h0000

// status fields
`define STB_ST_CH1_BIT      0
`define STB_ST_CH2_BIT      1
`define STB_ST_BLOCK_BIT    2
`define STB_ST_ESTOP_BIT    3
`define STB_ST_TERR_BIT     4
`define STB_ST_MON_BIT      5
`define STB_ST_DB_BIT       6

// interrupt bits
`define STB_IRQ_BLOCK_BIT   0
`define STB_IRQ_TERR_BIT    1
`define STB_IRQ_W           2

// display codes
`define STB_DISP_BLOCK      8'hBB
`define STB_DISP_RUN        8'h00
`define STB_DISP_IDLE       8'h01

`endif

// file: design/stb_safe_torque.v
`timescale 1ns/100ps
`include "stb_defines.vh"

module stb_safe_torque #(
    parameter FILT_CYC     = `STB_FILT_CYC,
    parameter MISMATCH_CYC = `STB_MISMATCH_CYC,
    parameter DELAY_W      = 16
) (
    // clock and reset
    input  wire        mclk,
    input  wire        reset,
    // safety inputs, high means on (current flowing)
    input  wire        safety_input_ch1,
    input  wire        safety_input_ch2,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // side outputs
    output reg         brake_release_out,
    output reg         servo_alarm_out,
    output reg         external_fault_monitor_out,
    output reg         drive_enable_out,
    output reg         dyn_brake_out,
    output reg  [7:0]  display_code_out,
    output reg         irq_out
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_RUN   = 3'b001;
localparam ST_DELAY = 3'b010;
localparam ST_OFF   = 3'b100;
localparam [31:0] FILT_LIM = FILT_CYC - 1;
localparam [31:0] MISM_LIM = MISMATCH_CYC - 1;
localparam [31:0] MISM_CAP = MISMATCH_CYC;

function sel_addr;
    input [7:0] a;
    input [7:0] b;
    begin
        sel_addr = (a == b);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// input synchroniser and pulse filter per channel
wire [1:0] raw_in = {safety_input_ch2, safety_input_ch1};
wire [1:0] filt_on;

genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ch
        reg [`STB_SYNC_CYC-1:0] sync_r;
        reg [31:0]              cnt_r;
        reg                     on_r;
        always @(posedge mclk)
        begin
            if (reset)
            begin
                sync_r <= {`STB_SYNC_CYC{1'b1}};
                cnt_r  <= 32'h0000_0000;
                on_r   <= 1'b1;
            end
            else
            begin
                sync_r <= {sync_r[`STB_SYNC_CYC-2:0], raw_in[g]};
                if (sync_r[`STB_SYNC_CYC-1] == on_r)
                    cnt_r <= 32'h0000_0000;
                else if (cnt_r >= FILT_LIM)
                begin
                    on_r  <= sync_r[`STB_SYNC_CYC-1];
                    cnt_r <= 32'h0000_0000;
                end
                else
                    cnt_r <= cnt_r + 32'h0000_0001;
            end
        end
        assign filt_on[g] = on_r;
    end
endgenerate

wire block_req  = ~filt_on[0] | ~filt_on[1];
wire both_off   = ~filt_on[0] & ~filt_on[1];
wire mismatch   = filt_on[0] ^ filt_on[1];

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0]         ctrl_r;
reg [DELAY_W-1:0] delay_r;
wire [1:0]        irq_stat;
reg [1:0]         irq_mask_r;
reg [2:0]         state_r;
reg [2:0]         state_nxt;
reg [DELAY_W-1:0] dcnt_r;
reg [31:0]        mcnt_r;
reg               terr_r;
reg               estop_r;
reg               block_d_r;

wire [3:0] stop_mode = ctrl_r[`STB_CTRL_MODE_LSB +: `STB_CTRL_MODE_W];
wire       servo_on  = ctrl_r[`STB_CTRL_SVON_BIT];
wire       use_db    = (stop_mode == 4'h0) | (stop_mode == 4'h1);
wire       wr_ctrl   = reg_wr & sel_addr(reg_addr, `STB_REG_CTRL);
wire       wr_stat   = reg_wr & sel_addr(reg_addr, `STB_REG_IRQ_STAT);
wire       wr_mask   = reg_wr & sel_addr(reg_addr, `STB_REG_IRQ_MASK);
wire       wr_delay  = reg_wr & sel_addr(reg_addr, `STB_REG_DELAY);
wire       block_on  = state_r == ST_OFF;
wire       block_rise = block_req & ~block_d_r;
wire       terr_set  = mismatch & (mcnt_r >= MISM_LIM);

////////////////////////////////////////////////////////////////////////////////
// servo state machine
always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_RUN:
            if (block_req)
                state_nxt = ST_OFF;
            else if (!servo_on)
                state_nxt = (delay_r == {DELAY_W{1'b0}}) ? ST_OFF : ST_DELAY;
        ST_DELAY:
            if (block_req)
                state_nxt = ST_OFF;
            else if (servo_on)
                state_nxt = ST_RUN;
            else if (dcnt_r >= delay_r - 1'b1)
                state_nxt = ST_OFF;
        ST_OFF:
            if (!block_req && servo_on && !block_d_r)
                state_nxt = ST_RUN;
        default:
            state_nxt = ST_OFF;
    endcase
end

always @(posedge mclk)
begin
    if (reset)
    begin
        state_r   <= ST_OFF;
        dcnt_r    <= {DELAY_W{1'b0}};
        block_d_r <= 1'b0;
    end
    else
    begin
        state_r   <= state_nxt;
        block_d_r <= block_req;
        dcnt_r    <= (state_r == ST_DELAY) ? dcnt_r + 1'b1 : {DELAY_W{1'b0}};
    end
end

////////////////////////////////////////////////////////////////////////////////
// software registers
always @(posedge mclk)
begin
    if (reset)
    begin
        ctrl_r     <= `STB_CTRL_RST;
        delay_r    <= `STB_DELAY_RST;
        irq_mask_r <= 2'h0;
    end
    else
    begin
        // a block request drops servo on, so restart needs a fresh write
        if (wr_ctrl)
            ctrl_r <= reg_wdata[7:0];
        else if (block_req)
            ctrl_r[`STB_CTRL_SVON_BIT] <= 1'b0;
        if (wr_delay)
            delay_r <= reg_wdata[DELAY_W-1:0];
        if (wr_mask)
            irq_mask_r <= reg_wdata[1:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// channel mismatch timer, timing error and emergency-stop flag
always @(posedge mclk)
begin
    if (reset)
    begin
        mcnt_r  <= 32'h0000_0000;
        terr_r  <= 1'b0;
        estop_r <= 1'b0;
    end
    else
    begin
        // saturates so a long mismatch cannot wrap and rearm
        if (mismatch)
            mcnt_r <= (mcnt_r < MISM_CAP) ? mcnt_r + 32'h0000_0001 : mcnt_r;
        else
            mcnt_r <= 32'h0000_0000;
        if (terr_set)
            terr_r <= 1'b1;
        else if (wr_ctrl && reg_wdata[`STB_CTRL_ALM_BIT])
            terr_r <= 1'b0;
        if (block_rise)
            estop_r <= 1'b1;
        else if (!block_req)
            estop_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sticky interrupt status, a set wins over a clear in the same cycle
wire [`STB_IRQ_W-1:0] irq_set;

assign irq_set[`STB_IRQ_BLOCK_BIT] = block_rise;
assign irq_set[`STB_IRQ_TERR_BIT]  = terr_set;

genvar k;
generate
    for (k = 0; k < `STB_IRQ_W; k = k + 1)
    begin : g_irq
        reg stat_r;
        always @(posedge mclk)
        begin
            if (reset)
                stat_r <= 1'b0;
            else if (irq_set[k])
                stat_r <= 1'b1;
            else if (wr_stat && reg_wdata[k])
                stat_r <= 1'b0;
        end
        assign irq_stat[k] = stat_r;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// side outputs
always @(posedge mclk)
begin
    if (reset)
    begin
        brake_release_out          <= 1'b0;
        servo_alarm_out            <= 1'b0;
        external_fault_monitor_out <= 1'b0;
        drive_enable_out           <= 1'b0;
        dyn_brake_out              <= 1'b0;
    end
    else
    begin
        brake_release_out <= (state_nxt != ST_OFF) & ~block_req;
        drive_enable_out  <= (state_nxt == ST_RUN) & ~block_req;
        dyn_brake_out     <= (state_nxt != ST_RUN) & use_db;
        servo_alarm_out   <= terr_r & ~block_req & ~block_on;
        external_fault_monitor_out <= both_off;
    end
end

always @(posedge mclk)
begin
    if (reset)
    begin
        display_code_out <= `STB_DISP_IDLE;
        irq_out          <= 1'b0;
    end
    else
    begin
        if (block_req | block_on & block_d_r)
            display_code_out <= `STB_DISP_BLOCK;
        else
            display_code_out <= (state_r == ST_RUN) ? `STB_DISP_RUN : `STB_DISP_IDLE;
        irq_out <= |(irq_stat & irq_mask_r);
    end
end

////////////////////////////////////////////////////////////////////////////////
// register read port, data stand for one cycle only
always @(posedge mclk)
begin
    if (reset)
        reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
        case (reg_addr)
            `STB_REG_CTRL:     reg_rdata <= {24'h00_0000, ctrl_r};
            `STB_REG_STATUS:   reg_rdata <= {25'h000_0000, use_db,
                                   external_fault_monitor_out, terr_r, estop_r,
                                   block_on, filt_on[1], filt_on[0]};
            `STB_REG_IRQ_STAT: reg_rdata <= {30'h0000_0000, irq_stat};
            `STB_REG_IRQ_MASK: reg_rdata <= {30'h0000_0000, irq_mask_r};
            `STB_REG_DELAY:    reg_rdata <= {{(32-DELAY_W){1'b0}}, delay_r};
            default:           reg_rdata <= 32'h0000_0000;
        endcase
    end
    else
        reg_rdata <= 32'h0000_0000;
end

endmodule // stb_safe_torque

// file: bench/stb_chk_sva.sv
`timescale 1ns/100ps
`include "stb_defines.vh"
module stb_chk #(
    parameter FILT_CYC     = 4,
    parameter MISMATCH_CYC = 50
) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        safety_input_ch1,
    input wire logic        safety_input_ch2,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        brake_release_out,
    input wire logic        servo_alarm_out,
    input wire logic        external_fault_monitor_out,
    input wire logic        drive_enable_out,
    input wire logic [7:0]  display_code_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    wire blk = display_code_out == `STB_DISP_BLOCK;
    // held off long enough to pass sync and filter
    sequence s_ch1_off;
        (!safety_input_ch1)[*8];
    endsequence
    sequence s_both_off;
        (!safety_input_ch1 && !safety_input_ch2)[*8];
    endsequence
    a_block_on_off: assert property (s_ch1_off |-> ##[0:6] blk && !brake_release_out)
        else $error("no block after channel off");
    a_brake_no_delay: assert property ($rose(blk) |-> !brake_release_out)
        else $error("brake release late");
    a_alarm_quiet: assert property (blk |-> !servo_alarm_out)
        else $error("alarm while blocked");
    a_drive_cut: assert property (blk |-> !drive_enable_out)
        else $error("drive on while blocked");
    a_mon_one_on: assert property ((safety_input_ch1 || safety_input_ch2)[*8] |-> ##2
        !external_fault_monitor_out)
        else $error("monitor on with a channel on");
    a_mon_both_off: assert property (s_both_off |-> ##[0:6] external_fault_monitor_out)
        else $error("monitor late");
    a_block_cause: assert property ($rose(blk) |->
        $past(!safety_input_ch1 || !safety_input_ch2, 6))
        else $error("block without sustained off");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside slot");
endmodule // stb_chk
bind stb_safe_torque stb_chk #(.FILT_CYC(FILT_CYC), .MISMATCH_CYC(MISMATCH_CYC)) u_chk (
    .mclk(mclk), .reset(reset), .safety_input_ch1(safety_input_ch1),
    .safety_input_ch2(safety_input_ch2), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .brake_release_out(brake_release_out), .servo_alarm_out(servo_alarm_out),
    .external_fault_monitor_out(external_fault_monitor_out),
    .drive_enable_out(drive_enable_out), .display_code_out(display_code_out));

// file: bench/stb_safety_unit.sv
`timescale 1ns/100ps
module stb_safety_unit (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic open_ch1,
    input  wire logic open_ch2,
    input  wire logic monitor_in,
    output logic      ch1_out,
    output logic      ch2_out,
    output logic      unit_fault
);
    always @(posedge mclk)
    begin
        if (reset)
        begin
            ch1_out <= 1'b1;
            ch2_out <= 1'b1;
            unit_fault <= 1'b0;
        end
        // refuse to re-enable without monitor feedback
        else if (!ch1_out && !ch2_out && !(open_ch1 && open_ch2) && !monitor_in)
            unit_fault <= 1'b1;
        else
        begin
            ch1_out <= !open_ch1;
            ch2_out <= !open_ch2;
        end
    end
endmodule // stb_safety_unit

// file: bench/test_stb_safe_torque.sv
`timescale 1ns/100ps
`include "stb_defines.vh"
module test_stb_safe_torque;
    localparam MISM = 50;
    logic mclk, reset, open1, open2, ch1, ch2, ufault, reg_wr, reg_rd;
    logic brake, alarm, mon, drive, dynb, irq;
    logic [7:0] reg_addr, disp;
    logic [31:0] reg_wdata, reg_rdata, d;
    int num_errors, n_tests;
    stb_safe_torque #(.FILT_CYC(4), .MISMATCH_CYC(MISM)) u_dut (
        .mclk(mclk), .reset(reset), .safety_input_ch1(ch1), .safety_input_ch2(ch2),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .brake_release_out(brake), .servo_alarm_out(alarm),
        .external_fault_monitor_out(mon), .drive_enable_out(drive),
        .dyn_brake_out(dynb), .display_code_out(disp), .irq_out(irq));
    stb_safety_unit u_unit (.mclk(mclk), .reset(reset), .open_ch1(open1),
        .open_ch2(open2), .monitor_in(mon), .ch1_out(ch1), .ch2_out(ch2),
        .unit_fault(ufault));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task guard(input logic a, input logic b);
        @(posedge mclk);
        open1 <= a;
        open2 <= b;
    endtask
    task t_reset;
        chk({disp, brake, drive, mon, irq}, {`STB_DISP_IDLE, 4'h0});
        rd(`STB_REG_DELAY);
        chk(d, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20);
        chk(d, 32'h0000_0000);
        $display("test reset done");
    endtask
    task t_stop_modes;
        for (int m = 0; m < 4; m++)
        begin
            wr(`STB_REG_DELAY, 32'h0000_FFFF);
            wr(`STB_REG_CTRL, 32'h0000_0010 | m);
            cyc(4);
            chk({brake, drive, disp}, {2'b11, `STB_DISP_RUN});
            guard(1'b0, 1'b1);
            cyc(20);
            chk({brake, drive, alarm, mon, disp}, {4'h0, `STB_DISP_BLOCK});
            chk(dynb, m < 2);
            rd(`STB_REG_STATUS);
            chk({d[3], d[1:0]}, 3'b101);
            guard(1'b0, 1'b0);
            cyc(20);
        end
        $display("test stop modes done");
    endtask
    task t_short_pulse;
        wr(`STB_REG_CTRL, 32'h0000_0010);
        cyc(4);
        guard(1'b1, 1'b0);
        cyc(2);
        guard(1'b0, 1'b0);
        cyc(20);
        chk({drive, disp}, {1'b1, `STB_DISP_RUN});
        $display("test short pulse done");
    endtask
    task t_both_off;
        guard(1'b1, 1'b1);
        cyc(20);
        chk(mon, 1'b1);
        rd(`STB_REG_STATUS);
        chk(d[1:0], 2'b00);
        guard(1'b0, 1'b0);
        cyc(20);
        chk({ufault, mon}, 2'b00);
        $display("test both off done");
    endtask
    task t_mismatch;
        wr(`STB_REG_IRQ_MASK, 32'h0000_0003);
        guard(1'b1, 1'b0);
        cyc(MISM + 30);
        rd(`STB_REG_STATUS);
        chk({d[4], alarm, irq}, 3'b101);
        wr(`STB_REG_IRQ_MASK, 32'h0000_0000);
        cyc(2);
        chk(irq, 1'b0);
        guard(1'b0, 1'b0);
        cyc(20);
        wr(`STB_REG_IRQ_STAT, 32'h0000_0003);
        wr(`STB_REG_IRQ_MASK, 32'h0000_0003);
        cyc(2);
        chk(irq, 1'b0);
        wr(`STB_REG_CTRL, 32'h0000_0010);
        cyc(3);
        chk(alarm, 1'b1);
        wr(`STB_REG_CTRL, 32'h0000_0030);
        cyc(3);
        chk(alarm, 1'b0);
        $display("test mismatch done");
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        {num_errors, n_tests} = 0;
        {reset, open1, open2, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 44'h0};
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        cyc(1);
        t_reset;
        t_stop_modes;
        t_short_pulse;
        t_both_off;
        t_mismatch;
        tally_and_finish;
    end
    initial
    begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        tally_and_finish;
    end
endmodule // test_stb_safe_torque
